// >>> rtl/csfr_regs.sv
// Status and fault register bank of the charger, with one-shot processor-hot pulse.
// Assumes a byte register port from the serial management front end, one-cycle strobes.
`timescale 1ns/1ps
module csfr_regs
    import csfr_pkg::*;
#(
    parameter logic [PULSE_CNT_W-1:0] PULSE_100US = CYC_100US,
    parameter logic [PULSE_CNT_W-1:0] PULSE_1MS   = CYC_1MS,
    parameter logic [PULSE_CNT_W-1:0] PULSE_10MS  = CYC_10MS,
    parameter logic [PULSE_CNT_W-1:0] PULSE_5MS   = CYC_5MS
) (
    // Clock and reset
    input  wire logic                  CLOCK,
    input  wire logic                  RST_N,
    // Register port
    input  wire logic [7:0]            REG_ADDR,
    input  wire logic                  REG_WR,
    input  wire logic                  REG_RD,
    input  wire logic [7:0]            REG_WDATA,
    output logic      [7:0]            REG_RDATA,
    // Controls held elsewhere in the device
    input  wire logic                  FORCE_LATCHOFF_EN,
    input  wire logic [1:0]            PULSE_WIDTH_SEL,
    // Power stage conditions
    input  wire csfr_cond_s            COND,
    // Outputs
    output logic                       PROCHOT_N,
    output logic      [CUR_MA_W-1:0]   INPUT_CURRENT_LIMIT_MA
);

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    // ******************************************************************
    // Input synchronisers and agreement filter
    // ******************************************************************
    logic [COND_W-1:0] sync1;
    logic [COND_W-1:0] sync2;
    logic [COND_W-1:0] sync3;
    logic [COND_W-1:0] filt;
    csfr_cond_s        c;

    genvar gi;
    generate
        for (gi = 0; gi < COND_W; gi++) begin : g_sync
            always_ff @(posedge CLOCK) begin
                if (!RST_N) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    sync3[gi] <= 1'b0;
                    filt[gi]  <= 1'b0;
                end else begin
                    sync1[gi] <= COND[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    // Short glitches that stages two and three disagree on are dropped
                    if (sync2[gi] == sync3[gi]) begin
                        filt[gi] <= sync3[gi];
                    end
                end
            end
        end
    endgenerate

    assign c = csfr_cond_s'(filt);

    // ******************************************************************
    // Access decode
    // ******************************************************************
    wire        wr_cur_low  = REG_WR && hit(REG_ADDR, OFF_INPUT_CURRENT_LOW);
    wire        wr_cur_high = REG_WR && hit(REG_ADDR, OFF_INPUT_CURRENT_HIGH);
    wire        wr_fault    = REG_WR && hit(REG_ADDR, OFF_FAULT_FLAGS);
    wire        rd_fault    = REG_RD && hit(REG_ADDR, OFF_FAULT_FLAGS);
    wire        rd_alert    = REG_RD && hit(REG_ADDR, OFF_ALERT_SOURCE);

    // ******************************************************************
    // Registers
    // ******************************************************************
    logic [7:0] cur_low;
    logic [7:0] cur_high;
    logic [7:0] fault;
    logic [7:0] alert;
    logic       bus_prev;
    logic       cell_prev;

    // Stored so the host can read back and preserve it
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            cur_low <= RST_INPUT_CURRENT_LOW;
        end else if (wr_cur_low) begin
            cur_low <= REG_WDATA;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            cur_high <= RST_INPUT_CURRENT_HIGH;
        end else if (wr_cur_high) begin
            cur_high <= REG_WDATA;
        end
    end

    wire [CUR_MA_W-1:0] next_limit_ma =
        CUR_MA_W'(cur_high[CUR_CODE_W-1:0] * CUR_STEP_MA) + CUR_OFFSET_MA;

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            INPUT_CURRENT_LIMIT_MA <= CUR_MA_W'(RST_INPUT_CURRENT_HIGH[CUR_CODE_W-1:0])
                                      * CUR_STEP_MA + CUR_OFFSET_MA;
        end else begin
            INPUT_CURRENT_LIMIT_MA <= next_limit_ma;
        end
    end

    // ******************************************************************
    // Fault flags
    // ******************************************************************
    wire [7:0] fault_cond = {c.input_overvoltage, c.battery_overcurrent, c.input_overcurrent,
                             c.system_overvoltage, c.system_short, c.forced_shutdown,
                             c.reverse_overvoltage, c.reverse_undervoltage};

    // A present condition always sets: set wins over any clear in the same cycle
    wire [7:0] rd_clear  = rd_fault ? FLT_READ_CLEAR_MASK : 8'h00;
    wire [7:0] wr_clear  = wr_fault ? (FLT_WRITE_CLEAR_MASK & ~REG_WDATA) : 8'h00;
    wire       off_clear = !FORCE_LATCHOFF_EN;
    wire [7:0] lo_clear  = {5'h00, off_clear, 2'h0};
    wire [7:0] next_fault = fault_cond | (fault & ~(rd_clear | wr_clear | lo_clear));

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            fault <= RST_FAULT_FLAGS;
        end else begin
            fault <= next_fault;
        end
    end

    // ******************************************************************
    // Operating status, live from the filtered levels
    // ******************************************************************
    wire [7:0] status = {
        c.bus_above_conversion,
        c.current_optimizer_done,
        c.peak_assist_mode,
        c.reverse_output_mode ? c.output_voltage_loop : c.input_voltage_loop,
        c.reverse_output_mode ? c.discharge_current_loop : c.input_current_loop,
        c.fast_charge,
        c.precharge,
        c.reverse_output_mode
    };

    // ******************************************************************
    // Alert sources and removal events
    // ******************************************************************
    wire adapter_loss = bus_prev && !c.bus_above_conversion;
    wire cell_loss    = !cell_prev && c.cell_below_loss;
    wire [7:0] alert_set = {c.alert_trigger, cell_loss, adapter_loss};
    // Alert bits are held until read; a trigger in the read cycle survives
    wire [7:0] next_alert = alert_set | (rd_alert ? 8'h00 : alert);

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            alert     <= RST_ALERT_SOURCE;
            bus_prev  <= 1'b0;
            cell_prev <= 1'b0;
        end else begin
            alert     <= next_alert;
            bus_prev  <= c.bus_above_conversion;
            cell_prev <= c.cell_below_loss;
        end
    end

    // ******************************************************************
    // One-shot processor-hot pulse
    // ******************************************************************
    logic [PULSE_CNT_W-1:0] pulse_cnt;
    logic [PULSE_CNT_W-1:0] pulse_len;

    always_comb begin
        case (csfr_width_e'(PULSE_WIDTH_SEL))
            CSFR_PW_100US: pulse_len = PULSE_100US;
            CSFR_PW_1MS:   pulse_len = PULSE_1MS;
            CSFR_PW_10MS:  pulse_len = PULSE_10MS;
            CSFR_PW_5MS:   pulse_len = PULSE_5MS;
            default:       pulse_len = PULSE_10MS;
        endcase
    end

    wire pulse_start = adapter_loss || cell_loss;
    wire [PULSE_CNT_W-1:0] next_pulse_cnt =
        pulse_start ? pulse_len : (pulse_cnt != '0) ? pulse_cnt - 1'b1 : pulse_cnt;

    // Output low exactly for pulse_len cycles; a new event restarts the count
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            pulse_cnt <= '0;
            PROCHOT_N <= 1'b1;
        end else begin
            pulse_cnt <= next_pulse_cnt;
            PROCHOT_N <= (next_pulse_cnt == '0);
        end
    end

    // ******************************************************************
    // Read data
    // ******************************************************************
    logic [7:0] rd_mux;

    always_comb begin
        case (REG_ADDR)
            OFF_INPUT_CURRENT_LOW:  rd_mux = cur_low;
            OFF_INPUT_CURRENT_HIGH: rd_mux = cur_high;
            OFF_FAULT_FLAGS:        rd_mux = fault;
            OFF_OPERATING_STATUS:   rd_mux = status;
            OFF_ALERT_SOURCE:       rd_mux = alert;
            default:                rd_mux = UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            REG_RDATA <= rd_mux;
        end
    end

endmodule

// >>> rtl/csfr_pkg.sv
// Constants, field layouts and carrier types for the charger status and fault bank.
// Assumes one 100 MHz clock; all analog condition levels arrive asynchronously.
// Notes on behaviour
// - Input current limit spans 50 to 6400 mA in 50 mA steps from high byte.
// - Code zero means 50 mA; the offset adds to the weighted code sum.
// - Input overvoltage, overcurrent and reverse fault flags latch; read clears them once fault is gone.
// - System overvoltage and short flags latch until the host writes zero there.
// - Forced shutdown flag clears only when the force latch-off control is disabled.
// - After reset the fault register reads forced shutdown and reverse overvoltage set.
// - Status bit 7 shows input present, bus above conversion threshold.
// - Status bit 6 shows the current optimizer has finished.
// - Status bit 5 shows peak-assist mode is active.
// - Status bit 4 shows input voltage loop forward, or output voltage loop reverse.
// - Status bit 3 shows input current loop forward, or discharge loop reverse.
// - Status bit 2 shows fast charge.
// - Status bit 1 shows precharge.
// - Status bit 0 shows reverse output mode.
// - Alert source bits 7 to 2 record each alert trigger level; these do not pulse processor-hot.
// - Bus dropping below conversion threshold pulses processor-hot and sets bit 0.
// - Pulse length select: 00 100us, 01 1ms, 10 10ms, 11 5ms; default 10ms.
package csfr_pkg;

    // ******************************************************************
    // Register map
    // ******************************************************************
    localparam logic [7:0] OFF_INPUT_CURRENT_LOW  = 8'h0E;
    localparam logic [7:0] OFF_INPUT_CURRENT_HIGH = 8'h0F;
    localparam logic [7:0] OFF_FAULT_FLAGS        = 8'h20;
    localparam logic [7:0] OFF_OPERATING_STATUS   = 8'h21;
    localparam logic [7:0] OFF_ALERT_SOURCE       = 8'h22;

    localparam logic [7:0] RST_INPUT_CURRENT_LOW  = 8'h00;
    localparam logic [7:0] RST_INPUT_CURRENT_HIGH = 8'h41;
    localparam logic [7:0] RST_FAULT_FLAGS        = 8'h06;
    localparam logic [7:0] RST_ALERT_SOURCE       = 8'h00;
    localparam logic [7:0] UNMAPPED_READ          = 8'h00;

    // ******************************************************************
    // Fault flag fields
    // ******************************************************************
    localparam int FLT_INPUT_OV    = 7;
    localparam int FLT_BATTERY_OC  = 6;
    localparam int FLT_INPUT_OC    = 5;
    localparam int FLT_SYSTEM_OV   = 4;
    localparam int FLT_SYSTEM_SHORT = 3;
    localparam int FLT_FORCED_OFF  = 2;
    localparam int FLT_REVERSE_OV  = 1;
    localparam int FLT_REVERSE_UV  = 0;
    // Flags cleared by a read once their fault has gone
    localparam logic [7:0] FLT_READ_CLEAR_MASK  = 8'hE3;
    localparam logic [7:0] FLT_WRITE_CLEAR_MASK = 8'h18;

    // Alert source fields
    localparam int ALR_CELL_LOSS    = 1;
    localparam int ALR_ADAPTER_LOSS = 0;

    // ******************************************************************
    // Input current limit
    // ******************************************************************
    localparam int          CUR_CODE_W    = 7;
    localparam int          CUR_MA_W      = 13;
    localparam logic [12:0] CUR_STEP_MA   = 13'h0032;
    localparam logic [12:0] CUR_OFFSET_MA = 13'h0032;

    // ******************************************************************
    // Pulse timing
    // ******************************************************************
    localparam int PULSE_CNT_W   = 21;
    localparam int CLK_PERIOD_NS = 10;
    localparam int PULSE_SEL_100US_NS = 100_000;
    localparam int PULSE_SEL_1MS_NS   = 1_000_000;
    localparam int PULSE_SEL_10MS_NS  = 10_000_000;
    localparam int PULSE_SEL_5MS_NS   = 5_000_000;
    localparam logic [PULSE_CNT_W-1:0] CYC_100US = PULSE_CNT_W'(PULSE_SEL_100US_NS / CLK_PERIOD_NS);
    localparam logic [PULSE_CNT_W-1:0] CYC_1MS   = PULSE_CNT_W'(PULSE_SEL_1MS_NS / CLK_PERIOD_NS);
    localparam logic [PULSE_CNT_W-1:0] CYC_10MS  = PULSE_CNT_W'(PULSE_SEL_10MS_NS / CLK_PERIOD_NS);
    localparam logic [PULSE_CNT_W-1:0] CYC_5MS   = PULSE_CNT_W'(PULSE_SEL_5MS_NS / CLK_PERIOD_NS);
    localparam logic [1:0] PULSE_SEL_DEFAULT = 2'h2;

    typedef enum logic [1:0] {
        CSFR_PW_100US = 2'b00,
        CSFR_PW_1MS   = 2'b01,
        CSFR_PW_10MS  = 2'b10,
        CSFR_PW_5MS   = 2'b11
    } csfr_width_e;

    // ******************************************************************
    // Asynchronous condition levels from the power stage
    // ******************************************************************
    typedef struct packed {
        logic       input_overvoltage;
        logic       battery_overcurrent;
        logic       input_overcurrent;
        logic       system_overvoltage;
        logic       system_short;
        logic       forced_shutdown;
        logic       reverse_overvoltage;
        logic       reverse_undervoltage;
        logic       bus_above_conversion;
        logic       current_optimizer_done;
        logic       peak_assist_mode;
        logic       input_voltage_loop;
        logic       output_voltage_loop;
        logic       input_current_loop;
        logic       discharge_current_loop;
        logic       fast_charge;
        logic       precharge;
        logic       reverse_output_mode;
        logic [5:0] alert_trigger;
        logic       cell_below_loss;
    } csfr_cond_s;

    localparam int COND_W = $bits(csfr_cond_s);

endpackage

// >>> bench/csfr_regs_monitor.sv
// Checker bound to csfr_regs; it sees the top ports only.
// Assumes the host model reads every third edge and reads two edges after a write.
`timescale 1ns/1ps
module csfr_regs_monitor
    import csfr_pkg::*;
#(
    parameter logic [PULSE_CNT_W-1:0] PULSE_100US = CYC_100US,
    parameter logic [PULSE_CNT_W-1:0] PULSE_1MS   = CYC_1MS,
    parameter logic [PULSE_CNT_W-1:0] PULSE_10MS  = CYC_10MS,
    parameter logic [PULSE_CNT_W-1:0] PULSE_5MS   = CYC_5MS
) (
    // Watched ports
    input wire logic                CLOCK,
    input wire logic                RST_N,
    input wire logic [7:0]          REG_ADDR,
    input wire logic                REG_WR,
    input wire logic                REG_RD,
    input wire logic [7:0]          REG_WDATA,
    input wire logic [7:0]          REG_RDATA,
    input wire logic                FORCE_LATCHOFF_EN,
    input wire logic [1:0]          PULSE_WIDTH_SEL,
    input wire csfr_cond_s          COND,
    input wire logic                PROCHOT_N,
    input wire logic [CUR_MA_W-1:0] INPUT_CURRENT_LIMIT_MA
);
    csfr_cond_s             cond_q;
    logic [3:0]             stab;
    logic [PULSE_CNT_W-1:0] lo_cnt;
    wire logic              rev = COND.reverse_output_mode;
    wire logic [7:0]        flt = COND[24:17];
    wire logic [5:0]        alr = COND[6:1];
    wire logic [7:0]        st  = {COND[16:14], rev ? COND[12] : COND[13],
                                   rev ? COND[10] : COND[11], COND[9:7]};
    wire logic [PULSE_CNT_W-1:0] pw = PULSE_WIDTH_SEL[1] ?
        (PULSE_WIDTH_SEL[0] ? PULSE_5MS : PULSE_10MS) :
        (PULSE_WIDTH_SEL[0] ? PULSE_1MS : PULSE_100US);
    // Conditions must sit still past the filters before flags are judged
    wire logic              ok = stab >= 4'h6;

    always_ff @(posedge CLOCK) begin
        cond_q <= COND;
        if (!RST_N || COND != cond_q) stab <= 4'h0;
        else if (stab != 4'hF) stab <= stab + 4'h1;
        if (!RST_N || PROCHOT_N) lo_cnt <= '0;
        else lo_cnt <= lo_cnt + 1'b1;
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    sequence s_fault_rd; REG_RD && REG_ADDR == OFF_FAULT_FLAGS && ok; endsequence
    sequence s_fault_wr;
        REG_WR && REG_ADDR == OFF_FAULT_FLAGS && REG_WDATA[4:3] == 2'h0 && ok;
    endsequence
    sequence s_bus_drop; $fell(COND.bus_above_conversion) ##1 !COND.bus_above_conversion; endsequence

    property p_limit; REG_WR && REG_ADDR == OFF_INPUT_CURRENT_HIGH |-> ##2 INPUT_CURRENT_LIMIT_MA
        == 13'($past(REG_WDATA, 2) & 8'h7F) * CUR_STEP_MA + CUR_OFFSET_MA; endproperty
    a_limit: assert property (p_limit) else $error("limit wrong");
    property p_status; REG_RD && REG_ADDR == OFF_OPERATING_STATUS && ok |=> REG_RDATA == $past(st);
    endproperty
    a_status: assert property (p_status)
        else $error("status wrong");
    property p_fault_now; s_fault_rd |=> (REG_RDATA & $past(flt)) == $past(flt); endproperty
    a_fault_now: assert property (p_fault_now) else $error("flag lost");
    property p_rd_clear; s_fault_rd ##3 s_fault_rd |=>
        (REG_RDATA & FLT_READ_CLEAR_MASK & ~$past(flt)) == 8'h00; endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("read clear");
    property p_wr_clear; s_fault_wr ##2 s_fault_rd |=>
        (REG_RDATA & FLT_WRITE_CLEAR_MASK & ~$past(flt)) == 8'h00; endproperty
    a_wr_clear: assert property (p_wr_clear) else $error("write clear");
    property p_forced; s_fault_rd ##0 (!FORCE_LATCHOFF_EN && !$past(FORCE_LATCHOFF_EN)
        && !COND.forced_shutdown) |=> !REG_RDATA[2]; endproperty
    a_forced: assert property (p_forced) else $error("shutdown flag");
    property p_alert; REG_RD && REG_ADDR == OFF_ALERT_SOURCE && ok |=>
        (REG_RDATA[7:2] & $past(alr)) == $past(alr); endproperty
    a_alert: assert property (p_alert) else $error("alert source");
    property p_adapter; s_bus_drop |-> ##[1:6] !PROCHOT_N; endproperty
    a_adapter: assert property (p_adapter) else $error("adapter pulse");
    property p_cell; $rose(COND.cell_below_loss) |-> ##[3:7] !PROCHOT_N; endproperty
    a_cell: assert property (p_cell) else $error("cell pulse");
    property p_pulse; $rose(PROCHOT_N) |-> lo_cnt == pw; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse length");
endmodule

bind csfr_regs csfr_regs_monitor #(.PULSE_100US(PULSE_100US), .PULSE_1MS(PULSE_1MS),
    .PULSE_10MS(PULSE_10MS), .PULSE_5MS(PULSE_5MS)) mon_u (.CLOCK(CLOCK), .RST_N(RST_N),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .FORCE_LATCHOFF_EN(FORCE_LATCHOFF_EN),
    .PULSE_WIDTH_SEL(PULSE_WIDTH_SEL), .COND(COND), .PROCHOT_N(PROCHOT_N),
    .INPUT_CURRENT_LIMIT_MA(INPUT_CURRENT_LIMIT_MA));

// >>> bench/csfr_host.sv
// Host model on the byte register port, standing for the serial front end.
// Assumes a strobe is taken at the rising edge after it is raised.
`timescale 1ns/1ps
module csfr_host
    import csfr_pkg::*;
(
    // Clock and answer
    input wire logic       clock,
    input wire logic [7:0] reg_rdata,
    // Requests
    output logic [7:0]     reg_addr,
    output logic           reg_wr,
    output logic           reg_rd,
    output logic [7:0]     reg_wdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        // Idle lines carry the inverse so a stale value never looks live
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clock);
        #1;
        d = reg_rdata;
    endtask
    task automatic keep_low;
        logic [7:0] v;
        rd(OFF_INPUT_CURRENT_LOW, v);
        wr(OFF_INPUT_CURRENT_LOW, v);
    endtask
endmodule

// >>> bench/charger_status_fault_regs_bench.sv
// Self-checking bench for the charger status and fault bank.
// Assumes csfr_host on the register port and the bound checker on the ports.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %0t: got %0h expected %0h", $time, (g), (e)); end end
module charger_status_fault_regs_bench
    import csfr_pkg::*;
;
    // Short pulse counts keep the run brief: 4, 8, 16 and 12 cycles
    localparam logic [4*PULSE_CNT_W-1:0] PW = {21'h0_000C, 21'h0_0010, 21'h0_0008, 21'h0_0004};
    logic                clock, rst_n, force_en, reg_wr, reg_rd, prochot_n;
    logic [1:0]          sel;
    csfr_cond_s          cond;
    logic [7:0]          reg_addr, reg_wdata, reg_rdata;
    logic [CUR_MA_W-1:0] limit_ma;
    logic [PULSE_CNT_W-1:0] n;
    int                  err_count, tests_run, cyc;

    csfr_regs #(.PULSE_100US(PW[0 +: PULSE_CNT_W]), .PULSE_1MS(PW[PULSE_CNT_W +: PULSE_CNT_W]),
        .PULSE_10MS(PW[2*PULSE_CNT_W +: PULSE_CNT_W]), .PULSE_5MS(PW[3*PULSE_CNT_W +: PULSE_CNT_W])
    ) dut_u (.CLOCK(clock), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .FORCE_LATCHOFF_EN(force_en), .PULSE_WIDTH_SEL(sel), .COND(cond),
        .PROCHOT_N(prochot_n), .INPUT_CURRENT_LIMIT_MA(limit_ma));
    csfr_host host_u (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

    always #5 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            err_count++;
            wrap_up;
        end
    end

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host_u.rd(a, d);
        `CHK(d, e)
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge clock);
    endtask

    task automatic t_reset;
        rc(OFF_INPUT_CURRENT_LOW, 8'h00);
        rc(OFF_INPUT_CURRENT_HIGH, 8'h41);
        `CHK(limit_ma, 13'h0CE4)
        rc(OFF_FAULT_FLAGS, 8'h06);
        rc(OFF_FAULT_FLAGS, 8'h04);
        rc(OFF_OPERATING_STATUS, 8'h00);
        rc(OFF_ALERT_SOURCE, 8'h00);
        rc(8'h30, 8'h00);
    endtask
    task automatic t_limit;
        logic [7:0] c [3];
        c = '{8'h00, 8'hFF, 8'h41};
        foreach (c[i]) begin
            host_u.wr(OFF_INPUT_CURRENT_HIGH, c[i]);
            rc(OFF_INPUT_CURRENT_HIGH, c[i]);
            `CHK(limit_ma, 13'(c[i][6:0]) * 13'h0032 + 13'h0032)
        end
        host_u.keep_low;
        rc(OFF_INPUT_CURRENT_LOW, 8'h00);
    endtask
    task automatic t_fault;
        @(posedge clock);
        cond[24:17] <= 8'hFF;
        wt(8);
        rc(OFF_FAULT_FLAGS, 8'hFF);
        rc(OFF_FAULT_FLAGS, 8'hFF);
        @(posedge clock);
        cond[24:17] <= 8'h00;
        wt(8);
        rc(OFF_FAULT_FLAGS, 8'hFF);
        rc(OFF_FAULT_FLAGS, 8'h1C);
        host_u.wr(OFF_FAULT_FLAGS, 8'hFF);
        rc(OFF_FAULT_FLAGS, 8'h1C);
        host_u.wr(OFF_FAULT_FLAGS, 8'h00);
        rc(OFF_FAULT_FLAGS, 8'h04);
        host_u.wr(OFF_OPERATING_STATUS, 8'hFF);
        host_u.wr(OFF_ALERT_SOURCE, 8'hFF);
        rc(OFF_OPERATING_STATUS, 8'h00);
        rc(OFF_ALERT_SOURCE, 8'h00);
        @(posedge clock);
        force_en <= 1'b0;
        rc(OFF_FAULT_FLAGS, 8'h00);
    endtask
    task automatic t_status;
        logic [9:0] s;
        logic [7:0] e;
        for (int k = 0; k < 20; k++) begin
            s = (10'h001 << (k % 10)) | 10'(k / 10);
            e = {s[9:7], s[0] ? s[5] : s[6], s[0] ? s[3] : s[4], s[2:0]};
            @(posedge clock);
            cond[16:7] <= s;
            wt(8);
            rc(OFF_OPERATING_STATUS, e);
        end
        @(posedge clock);
        cond[16:7] <= 10'h000;
        wt(30);
    endtask
    task automatic t_pulse;
        for (int s = 0; s < 4; s++) begin
            @(posedge clock);
            sel <= 2'(s);
            cond.bus_above_conversion <= 1'b1;
            wt(8);
            cond.bus_above_conversion <= 1'b0;
            n = '0;
            for (int w = 0; w < 20 && prochot_n !== 1'b0; w++) @(posedge clock) #1;
            while (prochot_n === 1'b0 && n < 21'h0_0040) begin
                @(posedge clock) #1;
                n++;
            end
            `CHK(n, PW[s*PULSE_CNT_W +: PULSE_CNT_W])
            rc(OFF_ALERT_SOURCE, 8'h01);
        end
        @(posedge clock);
        cond.cell_below_loss <= 1'b1;
        wt(20);
        rc(OFF_ALERT_SOURCE, 8'h02);
        @(posedge clock);
        cond[6:1] <= 6'h3F;
        wt(8);
        rc(OFF_ALERT_SOURCE, 8'hFC);
    endtask

    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        force_en = 1'b1;
        sel = 2'h0;
        cond = '0;
        err_count = 0;
        tests_run = 0;
        cyc = 0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        t_reset;
        t_limit;
        t_fault;
        t_status;
        t_pulse;
        wrap_up;
    end
endmodule
